// *** design/lstx_cfg.svh ***
/*
 * Constants of the LVDS transmitter control block: register map, field
 * positions, reset values, lane geometry, line patterns and timing counts.
 * Assumes inclusion by bare name from the package and the top module.
 */
`ifndef LSTX_CFG_SVH
`define LSTX_CFG_SVH

// Register byte offsets
`define LSTX_CTRL_OFF       12'h000
`define LSTX_STATUS_OFF     12'h004
`define LSTX_RATE_OFF       12'h008
`define LSTX_CYCLES_OFF     12'h00C

// Control field positions and reset value
`define LSTX_CTRL_PWR_BIT   0
`define LSTX_CTRL_RANGE_BIT 1
`define LSTX_CTRL_BAL_BIT   2
`define LSTX_CTRL_EMPH_BIT  3
`define LSTX_CTRL_RESET     4'h0

// Status field positions
`define LSTX_ST_TRAIN_BIT   0
`define LSTX_ST_LOCK_BIT    1
`define LSTX_ST_PWR_BIT     2

// Lane geometry
`define LSTX_DATA_W         48
`define LSTX_LANES          8
`define LSTX_LANE_BITS      6
`define LSTX_SYM_W          7

// Line patterns
`define LSTX_CLK_PATTERN    7'h63
`define LSTX_TRAIN_PATTERN  7'h0F

// Training entry: least count of low parallel clock cycles
`define LSTX_TRAIN_MIN_CYC  3'h4

// Rate measurement
`define LSTX_CLK_PERIOD_NS  100
`define LSTX_RATE_WIN_NS    10000
`define LSTX_RATE_WIN_CYC   (`LSTX_RATE_WIN_NS / `LSTX_CLK_PERIOD_NS)
`define LSTX_LO_MIN_MHZ     33
`define LSTX_LO_MAX_MHZ     40
`define LSTX_HI_MIN_MHZ     38
`define LSTX_HI_MAX_MHZ     112
`define LSTX_LO_MIN_CNT     (`LSTX_LO_MIN_MHZ * `LSTX_RATE_WIN_NS / 1000)
`define LSTX_LO_MAX_CNT     (`LSTX_LO_MAX_MHZ * `LSTX_RATE_WIN_NS / 1000)
`define LSTX_HI_MIN_CNT     (`LSTX_HI_MIN_MHZ * `LSTX_RATE_WIN_NS / 1000)
`define LSTX_HI_MAX_CNT     (`LSTX_HI_MAX_MHZ * `LSTX_RATE_WIN_NS / 1000)

`endif

// *** design/lstx_pkg.sv ***
/*
 * Types of the LVDS transmitter control block.
 * Assumes the constants header is on the include path.
 */
`include "lstx_cfg.svh"

package lstx_pkg;

    // Control register image, bit 3 first
    typedef struct packed {
        logic emphasis;
        logic balance;
        logic range_high;
        logic power_up;
    } lstx_ctrl_t;

    typedef logic [`LSTX_SYM_W-1:0] lstx_sym_t;

    typedef logic [`LSTX_LANES-1:0][`LSTX_SYM_W-1:0] lstx_lanes_t;

endpackage

// *** design/lstx_top.sv ***
/*
 * Control logic of a 48-bit parallel-to-LVDS transmitter: parallel word
 * capture, per-lane DC-balance coding, skew training, power-down and an
 * APB register file with clock-rate supervision of the chosen PLL range.
 * Assumes parallel_clock_in is an unrelated clock from the host, that the
 * serial symbols are shifted out by an analog serializer cell, and that
 * the pads resolve the output enable into high impedance.
 */
// Chosen here: the APB interface to the registers and the register addresses.
// Functional notes
// - Parallel word captured on rising edge of the parallel clock.
// - Power-down low tri-states serial data and clock outputs.
// - Range select high means 38 to 112 MHz, low means 33 to 40 MHz.
// - During skew training no host data words are sampled.
// - Training only honoured while DC-balanced coding is selected.
// - Balance select high enables DC-balanced coding, low disables it.
// - Unconnected or unset controls read as low by default.
// - Emphasis select low gives normal levels, high enables pre-emphasis.
`include "lstx_cfg.svh"

module lstx_top
    import lstx_pkg::*;
(
    // System clock and reset
    input  wire logic         clk,
    input  wire logic         rst_n,
    // APB slave
    input  wire logic         psel,
    input  wire logic         penable,
    input  wire logic         pwrite,
    input  wire logic [11:0]  paddr,
    input  wire logic [31:0]  pwdata,
    output logic      [31:0]  prdata,
    output logic              pready,
    output logic              pslverr,
    // Parallel host side
    input  wire logic         parallel_clock_in,
    input  wire logic [47:0]  parallel_data_in,
    input  wire logic         skew_training_n,
    // Serial line side
    output lstx_lanes_t       serial_data_out_pos,
    output lstx_lanes_t       serial_data_out_neg,
    output lstx_sym_t         serial_clock_out_pos,
    output lstx_sym_t         serial_clock_out_neg,
    output logic              serial_oe,
    // Analog controls
    output logic              pll_range_high,
    output logic              emphasis_enable
);

    // Per-lane coder: returns {running disparity, symbol}
    function automatic logic [11:0] code_lane(input logic signed [4:0] rd,
                                              input logic [5:0]        d,
                                              input logic              dc_neutral_select);
        logic signed [4:0] disp;
        logic              inv;
        logic signed [4:0] rd_n;
        begin
            disp = $signed({1'b0, 3'($countones(d)), 1'b0}) - 5'sh06;
            inv  = dc_neutral_select && (rd != 5'sh00) && (disp != 5'sh00) && (rd[4] == disp[4]);
            if (!dc_neutral_select) begin
                rd_n = 5'sh00;
            end else if (inv) begin
                rd_n = rd - disp;
            end else begin
                rd_n = rd + disp;
            end
            code_lane = {rd_n, inv, (inv ? ~d : d)};
        end
    endfunction

    function automatic logic [15:0] to_gray(input logic [15:0] b);
        to_gray = b ^ (b >> 1);
    endfunction

    function automatic logic [15:0] from_gray(input logic [15:0] g);
        logic [15:0] b;
        begin
            b[15] = g[15];
            for (int i = 14; i >= 0; i--) begin
                b[i] = b[i+1] ^ g[i];
            end
            from_gray = b;
        end
    endfunction

    // ---------------- System domain: APB registers ----------------
    lstx_ctrl_t  ctrl_r;
    logic [31:0] prdata_r;
    logic        pslverr_r;
    logic        lock_r;
    logic [15:0] rate_r;
    logic [15:0] last_r;
    logic [6:0]  win_cnt_r;
    logic [15:0] gray_meta_r;
    logic [15:0] gray_s_r;
    logic        train_meta_r;
    logic        train_s_r;
    logic        train_r;
    logic [15:0] gray_src_r;

    wire         apb_setup = psel && !penable;
    wire         apb_wr    = psel && penable && pwrite;
    wire         word_ok   = (paddr[1:0] == 2'h0);
    wire         hit_ctrl  = word_ok && (paddr == `LSTX_CTRL_OFF);
    wire         hit_stat  = word_ok && (paddr == `LSTX_STATUS_OFF);
    wire         hit_rate  = word_ok && (paddr == `LSTX_RATE_OFF);
    wire         hit_cyc   = word_ok && (paddr == `LSTX_CYCLES_OFF);
    wire         hit_any   = hit_ctrl || hit_stat || hit_rate || hit_cyc;
    wire [15:0]  cyc_s     = from_gray(gray_s_r);
    wire [31:0]  status_w  = {29'h0, ctrl_r.power_up, lock_r, train_s_r};
    wire [31:0]  rd_mux    = hit_ctrl ? {28'h0, ctrl_r} :
                             hit_stat ? status_w :
                             hit_rate ? {16'h0, rate_r} :
                             hit_cyc  ? {16'h0, cyc_s} : 32'h0;
    wire         win_done  = (win_cnt_r == 7'(`LSTX_RATE_WIN_CYC - 1));
    wire [15:0]  rate_nxt  = cyc_s - last_r;
    wire         in_lo     = (rate_nxt >= 16'(`LSTX_LO_MIN_CNT)) &&
                             (rate_nxt <= 16'(`LSTX_LO_MAX_CNT));
    wire         in_hi     = (rate_nxt >= 16'(`LSTX_HI_MIN_CNT)) &&
                             (rate_nxt <= 16'(`LSTX_HI_MAX_CNT));
    wire         lock_nxt  = ctrl_r.power_up && (ctrl_r.range_high ? in_hi : in_lo);

    assign pready          = 1'b1;
    assign prdata          = prdata_r;
    assign pslverr         = pslverr_r;
    assign pll_range_high  = ctrl_r.range_high;
    assign emphasis_enable = ctrl_r.emphasis;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ctrl_r <= `LSTX_CTRL_RESET;
        end else if (apb_wr && hit_ctrl) begin
            ctrl_r <= pwdata[3:0];
        end
    end

    // Read data and error prepared in setup, valid in the access phase
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            prdata_r  <= 32'h0;
            pslverr_r <= 1'b0;
        end else if (apb_setup) begin
            prdata_r  <= pwrite ? 32'h0 : rd_mux;
            pslverr_r <= !hit_any;
        end
    end

    always_ff @(posedge clk) begin
        gray_meta_r  <= gray_src_r;
        gray_s_r     <= gray_meta_r;
        train_meta_r <= train_r;
        train_s_r    <= train_meta_r;
    end

    // Parallel clock rate against the selected PLL range
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            win_cnt_r <= 7'h00;
            rate_r    <= 16'h0000;
            last_r    <= 16'h0000;
            lock_r    <= 1'b0;
        end else if (win_done) begin
            win_cnt_r <= 7'h00;
            rate_r    <= rate_nxt;
            last_r    <= cyc_s;
            lock_r    <= lock_nxt;
        end else begin
            win_cnt_r <= win_cnt_r + 7'h01;
        end
    end

    // ---------------- Link domain: parallel clock ----------------
    logic        lrst_meta_r;
    logic        lrst_n_r;
    lstx_ctrl_t  ctrl_meta_r;
    lstx_ctrl_t  ctrl_l_r;
    logic        skew_meta_r;
    logic        skew_l_r;
    logic [2:0]  low_cnt_r;
    logic        oe_r;
    logic [15:0] cyc_r;
    lstx_lanes_t pos_r;
    lstx_sym_t   clk_sym_r;
    logic signed [`LSTX_LANES-1:0][4:0] rd_r;

    lstx_lanes_t                        coded_w;
    logic signed [`LSTX_LANES-1:0][4:0] rd_nxt;

    wire         pwr_l       = ctrl_l_r.power_up;
    wire         bal_l       = ctrl_l_r.balance;
    wire [2:0]   low_cnt_nxt = (skew_l_r || !pwr_l) ? 3'h0 :
                               (low_cnt_r == `LSTX_TRAIN_MIN_CYC) ? low_cnt_r :
                               low_cnt_r + 3'h1;
    wire         train_nxt   = (low_cnt_nxt == `LSTX_TRAIN_MIN_CYC) && bal_l;
    wire         take_w      = pwr_l && !train_nxt;
    wire [15:0]  cyc_nxt     = pwr_l ? cyc_r + 16'h0001 : cyc_r;

    assign serial_data_out_pos  = pos_r;
    assign serial_data_out_neg  = ~pos_r;
    assign serial_clock_out_pos = clk_sym_r;
    assign serial_clock_out_neg = ~clk_sym_r;
    assign serial_oe            = oe_r;

    always_comb begin
        logic [11:0] res;
        res = 12'h000;
        for (int i = 0; i < `LSTX_LANES; i++) begin
            res        = code_lane(rd_r[i], parallel_data_in[i*6 +: 6], bal_l);
            coded_w[i] = res[6:0];
            rd_nxt[i]  = res[11:7];
        end
    end

    always_ff @(posedge parallel_clock_in) begin
        lrst_meta_r <= rst_n;
        lrst_n_r    <= lrst_meta_r;
        ctrl_meta_r <= ctrl_r;
        ctrl_l_r    <= ctrl_meta_r;
        skew_meta_r <= skew_training_n;
        skew_l_r    <= skew_meta_r;
    end

    // Training detect, gated by balanced coding
    always_ff @(posedge parallel_clock_in) begin
        if (!lrst_n_r) begin
            low_cnt_r <= 3'h0;
            train_r   <= 1'b0;
        end else begin
            low_cnt_r <= low_cnt_nxt;
            train_r   <= train_nxt;
        end
    end

    // Symbol capture on the rising edge
    always_ff @(posedge parallel_clock_in) begin
        if (!lrst_n_r || !pwr_l) begin
            pos_r <= '0;
            rd_r  <= '0;
        end else if (train_nxt) begin
            pos_r <= {`LSTX_LANES{`LSTX_TRAIN_PATTERN}};
        end else begin
            pos_r <= coded_w;
            rd_r  <= rd_nxt;
        end
    end

    always_ff @(posedge parallel_clock_in) begin
        if (!lrst_n_r) begin
            oe_r       <= 1'b0;
            clk_sym_r  <= 7'h00;
            cyc_r      <= 16'h0000;
            gray_src_r <= 16'h0000;
        end else begin
            oe_r       <= pwr_l;
            clk_sym_r  <= pwr_l ? `LSTX_CLK_PATTERN : 7'h00;
            cyc_r      <= cyc_nxt;
            gray_src_r <= to_gray(cyc_nxt);
        end
    end

    // ---------------- Checks ----------------
    chk_capture_rising_edge: assert property (
        @(posedge parallel_clock_in) disable iff (!lrst_n_r)
        (take_w && !bal_l) |=> (serial_data_out_pos[7] == {1'b0, $past(parallel_data_in[47:42])}))
        else $error("parallel word not captured on the rising edge");

    chk_powerdown_tristate: assert property (
        @(posedge parallel_clock_in) disable iff (!lrst_n_r)
        !pwr_l |=> (!serial_oe && serial_data_out_pos == '0))
        else $error("serial outputs enabled during power-down");

    chk_low_range_lock: assert property (
        @(posedge clk) disable iff (!rst_n)
        (win_done && !ctrl_r.range_high && rate_nxt > 16'(`LSTX_LO_MAX_CNT)) |=> !lock_r)
        else $error("lock reported above the low range");

    chk_high_range_lock: assert property (
        @(posedge clk) disable iff (!rst_n)
        (win_done && ctrl_r.power_up && ctrl_r.range_high &&
         rate_nxt >= 16'(`LSTX_HI_MIN_CNT) && rate_nxt <= 16'(`LSTX_HI_MAX_CNT)) |=> lock_r)
        else $error("no lock inside the high range");

    chk_train_entry_time: assert property (
        @(posedge parallel_clock_in) disable iff (!lrst_n_r)
        (!skew_l_r && bal_l && pwr_l)[*4] |=> train_r)
        else $error("training not entered after four low cycles");

    chk_train_ignores_data: assert property (
        @(posedge parallel_clock_in) disable iff (!lrst_n_r)
        train_r |-> (serial_data_out_pos == {`LSTX_LANES{`LSTX_TRAIN_PATTERN}}))
        else $error("host data passed during training");

    chk_train_needs_balance: assert property (
        @(posedge parallel_clock_in) disable iff (!lrst_n_r)
        train_r |-> $past(bal_l))
        else $error("training without balanced coding");

    chk_balance_symbol: assert property (
        @(posedge parallel_clock_in) disable iff (!lrst_n_r)
        (take_w && bal_l) |=> (serial_data_out_pos[0][5:0] ==
            (serial_data_out_pos[0][6] ? ~$past(parallel_data_in[5:0])
                                       : $past(parallel_data_in[5:0]))))
        else $error("balanced symbol does not match input");

    chk_reset_defaults: assert property (
        @(posedge clk) disable iff (!rst_n)
        $rose(rst_n) |-> (ctrl_r == `LSTX_CTRL_RESET && !emphasis_enable && !pll_range_high))
        else $error("controls not low after reset");

    chk_emphasis_follows: assert property (
        @(posedge clk) disable iff (!rst_n)
        (apb_wr && hit_ctrl) |=> (emphasis_enable == $past(pwdata[`LSTX_CTRL_EMPH_BIT])))
        else $error("emphasis select did not follow write");

    chk_clock_lane: assert property (
        @(posedge parallel_clock_in) disable iff (!lrst_n_r)
        serial_oe |-> (serial_clock_out_pos == `LSTX_CLK_PATTERN &&
                       serial_clock_out_neg == ~`LSTX_CLK_PATTERN))
        else $error("clock lane pattern wrong");

    chk_train_keeps_disparity: assert property (
        @(posedge parallel_clock_in) disable iff (!lrst_n_r)
        train_nxt |=> $stable(rd_r))
        else $error("running disparity moved during training");

    chk_plain_refuses_train: assert property (
        @(posedge parallel_clock_in) disable iff (!lrst_n_r)
        !bal_l |=> !train_r)
        else $error("training entered with plain coding");

    chk_powerdown_clock_off: assert property (
        @(posedge parallel_clock_in) disable iff (!lrst_n_r)
        !pwr_l |=> (serial_clock_out_pos == 7'h00 && !serial_oe))
        else $error("clock lane active during power-down");

    chk_lock_needs_power: assert property (
        @(posedge clk) disable iff (!rst_n)
        (win_done && !ctrl_r.power_up) |=> !lock_r)
        else $error("lock reported while powered down");

    chk_plain_flag_clear: assert property (
        @(posedge parallel_clock_in) disable iff (!lrst_n_r)
        (take_w && !bal_l) |=> (serial_data_out_pos[0] == {1'b0, $past(parallel_data_in[5:0])}))
        else $error("plain lane carries an inversion flag");

endmodule

// *** design/lstx_fix_note.sv ***
/*
 * Holds no logic: the whole block lives in the top module file.
 * Assumes nothing of its surroundings.
 */

// *** bench/lstx_rx_model.sv ***
/*
 * Behavioural model of the matching deserializer at the far end of the cable.
 * Assumes the forwarded clock is recovered as the parallel clock itself.
 */
module lstx_rx_model
    import lstx_pkg::*;
(
    // Recovered clock and power control
    input  wire logic        rx_clk,
    input  wire logic        rx_power_down_n,
    // Line side
    input  wire lstx_lanes_t line_pos,
    input  wire logic        line_oe,
    // Parallel output
    output logic [47:0]      rx_word
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [47:0] decoded;

    // Flag bit marks an inverted lane, plain lanes carry zero there
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            decoded[6*i +: 6] = line_pos[i][6] ? ~line_pos[i][5:0]
                                               : line_pos[i][5:0];
        end
    end

    always_ff @(posedge rx_clk) begin
        if (!rx_power_down_n) begin
            rx_word <= '0;
        end else if (line_oe) begin
            rx_word <= decoded;
        end
    end
endmodule

// *** bench/testbench.sv ***
/*
 * Self-checking bench of the transmitter control block with a receiver model.
 * Assumes the register offsets and line patterns of the constants header.
 */
`include "lstx_cfg.svh"

module testbench
    import lstx_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct packed {
        logic [31:0] wdata;
        logic [31:0] rdata;
        logic        range_hi;
        logic        emph;
    } lstx_row_t;

    logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, pclk;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd_data;
    logic        rd_err, skew_n, oe, range_hi, emph, rx_pd_n;
    logic [47:0] pdata, rx_word;
    lstx_lanes_t lanes_p, lanes_n;
    lstx_sym_t   clk_p, clk_n, s0, s1;
    int          bad_count, check_count;
    lstx_row_t   rows [4] = '{
        '{32'hFFFF_FFF0, 32'h0000_0000, 1'b0, 1'b0},
        '{32'h0000_0002, 32'h0000_0002, 1'b1, 1'b0},
        '{32'h0000_0008, 32'h0000_0008, 1'b0, 1'b1},
        '{32'h0000_000A, 32'h0000_000A, 1'b1, 1'b1}};
    logic [47:0] words [2] = '{48'h0123_4567_89AB, 48'hFEDC_BA98_7654};

    lstx_top i_lstx_top (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .parallel_clock_in(pclk), .parallel_data_in(pdata),
        .skew_training_n(skew_n), .serial_data_out_pos(lanes_p),
        .serial_data_out_neg(lanes_n), .serial_clock_out_pos(clk_p),
        .serial_clock_out_neg(clk_n), .serial_oe(oe), .pll_range_high(range_hi),
        .emphasis_enable(emph));

    lstx_rx_model i_lstx_rx_model (.rx_clk(pclk), .rx_power_down_n(rx_pd_n),
        .line_pos(lanes_p), .line_oe(oe), .rx_word(rx_word));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    initial begin
        pclk = 1'b0;
        #3;
        forever #6 pclk = ~pclk;
    end

    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        @(posedge clk);
        while (pready !== 1'b1 && n < 20) begin
            @(posedge clk);
            n++;
        end
        if (n == 20) bad_count++;
        rd_data = prdata;
        rd_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wait_p(input int n);
        repeat (n) @(posedge pclk);
    endtask

    task automatic finish_test;
        $display("checks=%0d mismatches=%0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    initial begin
        #5000000;
        bad_count++;
        finish_test();
    end

    initial begin
        {rst_n, psel, penable, pwrite, paddr, pwdata, pdata} = '0;
        {skew_n, rx_pd_n} = 2'h3;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        apb(1'b0, `LSTX_CTRL_OFF, 32'h0);
        check(rd_data, 32'h0);
        check(oe, 1'b0);
        apb(1'b0, 12'h010, 32'h0);
        check(rd_err, 1'b1);
        apb(1'b1, `LSTX_RATE_OFF, 32'hFFFF);
        check(rd_err, 1'b0);
        foreach (rows[i]) begin
            apb(1'b1, `LSTX_CTRL_OFF, rows[i].wdata);
            apb(1'b0, `LSTX_CTRL_OFF, 32'h0);
            check(rd_data, rows[i].rdata);
            repeat (2) @(posedge clk);
            check(range_hi, rows[i].range_hi);
            check(emph, rows[i].emph);
        end
        // Plain coding, words held for several parallel cycles
        apb(1'b1, `LSTX_CTRL_OFF, 32'h1);
        wait_p(6);
        foreach (words[i]) begin
            @(posedge pclk);
            pdata <= words[i];
            wait_p(4);
            check(rx_word, words[i]);
            check(lanes_p[5], {1'b0, words[i][35:30]});
            check(lanes_n, lstx_lanes_t'(~lanes_p));
            check(clk_p, `LSTX_CLK_PATTERN);
            check(clk_n, lstx_sym_t'(~`LSTX_CLK_PATTERN));
            check(oe, 1'b1);
        end
        // Lock follows the chosen range at an 83 MHz parallel clock
        apb(1'b1, `LSTX_CTRL_OFF, 32'h3);
        repeat (250) @(posedge clk);
        apb(1'b0, `LSTX_STATUS_OFF, 32'h0);
        check(rd_data[`LSTX_ST_LOCK_BIT], 1'b1);
        apb(1'b0, `LSTX_RATE_OFF, 32'h0);
        check(rd_data >= 32'h341 && rd_data <= 32'h342, 1'b1);
        apb(1'b1, `LSTX_CTRL_OFF, 32'h1);
        repeat (250) @(posedge clk);
        apb(1'b0, `LSTX_STATUS_OFF, 32'h0);
        check(rd_data[`LSTX_ST_LOCK_BIT], 1'b0);
        // Balanced coding alternates the inversion flag on all ones
        apb(1'b1, `LSTX_CTRL_OFF, 32'h5);
        @(posedge pclk);
        pdata <= 48'hFFFF_FFFF_FFFF;
        wait_p(5);
        #1 s0 = lanes_p[0];
        @(posedge pclk);
        #1 s1 = lanes_p[0];
        check(s0 ^ s1, 7'h7F);
        check(rx_word, 48'hFFFF_FFFF_FFFF);
        // Training with balance on, host data must be ignored
        @(posedge pclk);
        skew_n <= 1'b0; // and
        wait_p(7);
        pdata <= 48'h0;
        wait_p(3);
        for (int i = 0; i < `LSTX_LANES; i++) begin
            check(lanes_p[i], `LSTX_TRAIN_PATTERN);
        end
        apb(1'b0, `LSTX_STATUS_OFF, 32'h0);
        check(rd_data[`LSTX_ST_TRAIN_BIT], 1'b1);
        @(posedge pclk);
        skew_n <= 1'b1;
        wait_p(6);
        check(rx_word, 48'h0); // and
        // Training request refused without balanced coding
        apb(1'b1, `LSTX_CTRL_OFF, 32'h1);
        @(posedge pclk);
        skew_n <= 1'b0;
        pdata <= words[0];
        wait_p(10);
        check(lanes_p[0], {1'b0, words[0][5:0]});
        skew_n <= 1'b1;
        // Power down tri-states the line, receiver clears its word
        apb(1'b1, `LSTX_CTRL_OFF, 32'h0);
        wait_p(6);
        check(oe, 1'b0);
        check(clk_p, 7'h00);
        @(posedge pclk);
        rx_pd_n <= 1'b0;
        wait_p(2);
        check(rx_word, 48'h0);
        finish_test();
    end
endmodule
